// >>> verilog/bsq_pkg.sv
// constants, types and field layouts of the drive state sequencer
package bsq_pkg;

  localparam int CLK_HZ = 100_000_000;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_SPEED = 8'h04;
  localparam logic [7:0] REG_TICK = 8'h08;
  localparam logic [7:0] REG_PGAIN = 8'h0C;
  localparam logic [7:0] REG_IGAIN = 8'h10;
  localparam logic [7:0] REG_RAMP = 8'h14;
  localparam logic [7:0] REG_ENC = 8'h18;
  localparam logic [7:0] REG_RANGE = 8'h1C;
  localparam logic [7:0] REG_PWMCFG = 8'h20;
  localparam logic [7:0] REG_CHMAP = 8'h24;
  localparam logic [7:0] REG_TBCFG = 8'h28;
  localparam logic [15:0] TICK_DIV_RST = 16'h03E7;

  // ------------------------------------------------------------
  // fault codes
  // ------------------------------------------------------------
  localparam logic [2:0] fault_code_none = 3'h0;
  localparam logic [2:0] fault_code_overcurrent = 3'h1;
  localparam logic [2:0] fault_code_microcode_exc = 3'h2;
  localparam logic [2:0] fault_code_bad_opcode = 3'h3;
  localparam logic [2:0] fault_code_misc = 3'h4;

  // ------------------------------------------------------------
  // timing and drive configuration
  // ------------------------------------------------------------
  localparam int PWM_FREQ_HZ = 20000;
  localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_FREQ_HZ;
  localparam int DEAD_TIME_NS = 1000;
  localparam int DEAD_CYC = (DEAD_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int PI_FREQ_HZ = 500;
  localparam int PI_PERIOD_CYC = CLK_HZ / PI_FREQ_HZ;
  localparam int RAMP_TIME_MS = 250;
  localparam int SPEED_RANGE_RPM = 1200;
  localparam int SPEED_MIN_RPM = 10;
  localparam int POLE_PAIRS = 2;
  localparam int ENC_INC_PER_REV = 2000;
  localparam int RAMP_STEP = SPEED_RANGE_RPM * 1000 / (PI_FREQ_HZ * RAMP_TIME_MS);
  localparam logic [23:0] P_GAIN_RST = 24'h004000;
  localparam logic [23:0] I_GAIN_RST = 24'h001000;
  localparam int FILT_DIV = 64;
  localparam int FILT_SAMPLES = 3;
  localparam real FILT_REJECT_US = 1.707;
  localparam real FILT_PASS_US = 2.56;
  localparam int TB1_DIV = 2;
  localparam int TB2_DIV = 8;
  localparam int TB_PRESCALE = 1;
  localparam logic [2:0] TB1_LAST = 3'(TB1_DIV * TB_PRESCALE - 1);
  localparam logic [2:0] TB2_LAST = 3'(TB2_DIV * TB_PRESCALE - 1);
  localparam logic [5:0] FILT_LAST = 6'(FILT_DIV - 1);
  localparam logic [7:0] CH_DEC_A = 8'h01;
  localparam logic [7:0] CH_DEC_B = 8'h02;
  localparam logic [7:0] CH_DEC_IDX = 8'h03;
  localparam logic [7:0] CH_PWM_A = 8'h08;
  localparam logic [7:0] CH_PWM_B = 8'h0A;
  localparam logic [7:0] CH_PWM_C = 8'h0C;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_INIT, ST_STOP, ST_ENABLE, ST_RUN, ST_DISABLE, ST_MOTOR_FAULT, ST_GLOBAL_FAULT
  } bsq_state_type;

  typedef struct packed {
    logic microcode;
    logic badOpcode;
    logic misc;
  } bsq_exc_type;

  typedef struct packed {
    logic sw;
    logic oc;
    bsq_exc_type exc;
    logic onOk;
    logic offOk;
  } bsq_pin_type;

  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } bsq_pwm_type;

endpackage

// >>> verilog/bsq_in_filter.sv
// synchroniser and three-sample filter for encoder inputs
`timescale 1ns/10ps
`default_nettype none
module bsq_in_filter #(
  parameter int W = 3
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sampleTick,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] filtOut
);

  logic [W-1:0] syncA_r;
  logic [W-1:0] syncB_r;
  logic [W-1:0] hist0_r;
  logic [W-1:0] hist1_r;
  logic [W-1:0] hist0_nxt;
  logic [W-1:0] hist1_nxt;
  logic [W-1:0] filt_r;
  logic [W-1:0] filt_nxt;

  // ------------------------------------------------------------
  // sample history and agreement vote
  // ------------------------------------------------------------
  always_comb
  begin
    hist0_nxt = hist0_r;
    hist1_nxt = hist1_r;
    filt_nxt = filt_r;
    if (sampleTick)
    begin
      hist0_nxt = syncB_r;
      hist1_nxt = hist0_r;
      for (int i = 0; i < W; i++)
        if (syncB_r[i] == hist0_r[i] && hist0_r[i] == hist1_r[i])
          filt_nxt[i] = syncB_r[i];
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      syncA_r <= '0;
      syncB_r <= '0;
      hist0_r <= '0;
      hist1_r <= '0;
      filt_r <= '0;
    end
    else
    begin
      syncA_r <= pinIn;
      syncB_r <= syncA_r;
      hist0_r <= hist0_nxt;
      hist1_r <= hist1_nxt;
      filt_r <= filt_nxt;
    end
  end

  assign filtOut = filt_r;

endmodule
`default_nettype wire

// >>> verilog/bsq_sequencer.sv
// drive state sequencer with apb registers, timebases and pwm stage
`timescale 1ns/10ps
`default_nettype none
module bsq_sequencer #(
  parameter int PWM_PERIOD = bsq_pkg::PWM_PERIOD_CYC,
  parameter int PI_PERIOD = bsq_pkg::PI_PERIOD_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic switchOnPin,
  input wire logic overCurrentPin,
  input wire bsq_pkg::bsq_exc_type excPin,
  input wire logic pwmOnOkPin,
  input wire logic pwmOffOkPin,
  input wire logic [2:0] encPin,
  input wire logic [2:0] commSector,
  input wire logic [12:0] dutyIn,
  output bsq_pkg::bsq_pwm_type pwmOut,
  output logic alignReq,
  output logic [15:0] speedReqOut,
  output logic speedStrobe,
  output logic [23:0] pGainOut,
  output logic [23:0] iGainOut,
  output logic faultLed,
  output logic [2:0] faultCode,
  output logic ocArmed,
  output logic timebaseOneTick,
  output logic timebaseTwoTick,
  output logic [2:0] encFilt,
  output bsq_pkg::bsq_state_type appState
);

  bsq_pkg::bsq_pin_type syncA_r;
  bsq_pkg::bsq_pin_type pinS;
  logic [2:0] tb1Cnt_r, tb1Cnt_nxt, tb2Cnt_r, tb2Cnt_nxt;
  logic [5:0] filtCnt_r, filtCnt_nxt;
  logic [15:0] tickCnt_r, tickCnt_nxt;
  logic [17:0] piCnt_r, piCnt_nxt;
  logic [12:0] pwmCnt_r, pwmCnt_nxt;
  logic tb1Tick_r, tb1Tick_nxt, tb2Tick_r, tb2Tick_nxt, filtTick_r, filtTick_nxt;
  logic appTick_r, appTick_nxt, piTick_r, piTick_nxt;
  bsq_pkg::bsq_state_type state_r, state_nxt;
  logic pwmReq_r, pwmReq_nxt, ocArm_r, ocArm_nxt, faultLed_r, faultLed_nxt;
  logic tbRun_r, tbRun_nxt, alignReq_r, alignReq_nxt, ocPrev_r;
  logic [2:0] excPrev_r, excNow, faultCode_r, faultCode_nxt;
  logic signed [15:0] speedRamp_r, speedRamp_nxt, speedSet_r, speedSet_nxt;
  logic [15:0] speedOut_r, speedOut_nxt;
  logic speedStrobe_r, speedStrobe_nxt;
  logic ocEvent, excEvent, pwmOn;
  logic [15:0] tickDiv_r, tickDiv_nxt;
  logic [23:0] pGain_r, pGain_nxt, iGain_r, iGain_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  bsq_pkg::bsq_pwm_type pwm_r, pwm_nxt;

  function automatic logic regMapped(input logic [7:0] a);
    regMapped = (a[1:0] == 2'h0) && (a <= bsq_pkg::REG_TBCFG);
  endfunction

  function automatic logic signed [15:0] rampToward(input logic signed [15:0] cur, input logic signed [15:0] tgt);
    logic signed [16:0] step;
    step = 17'(bsq_pkg::RAMP_STEP);
    if (17'(tgt) > 17'(cur) + step)
      rampToward = 16'(17'(cur) + step);
    else if (17'(tgt) < 17'(cur) - step)
      rampToward = 16'(17'(cur) - step);
    else
      rampToward = tgt;
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers and encoder filter
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      syncA_r <= '0;
      pinS <= '0;
      ocPrev_r <= 1'b0;
      excPrev_r <= '0;
    end
    else
    begin
      syncA_r <= {switchOnPin, overCurrentPin, excPin, pwmOnOkPin, pwmOffOkPin};
      pinS <= syncA_r;
      ocPrev_r <= pinS.oc;
      excPrev_r <= excNow;
    end
  end

  bsq_in_filter #(.W(3)) encFilter (
    .clk_sys(clk_sys),
    .rst(rst),
    .sampleTick(filtTick_r),
    .pinIn(encPin),
    .filtOut(encFilt)
  );

  // ------------------------------------------------------------
  // timebases, periodic ticks, pwm carrier
  // ------------------------------------------------------------
  always_comb
  begin
    tb1Cnt_nxt = '0;
    tb2Cnt_nxt = '0;
    filtCnt_nxt = '0;
    tb1Tick_nxt = 1'b0;
    tb2Tick_nxt = 1'b0;
    filtTick_nxt = 1'b0;
    if (tbRun_r)
    begin
      tb1Tick_nxt = (tb1Cnt_r == bsq_pkg::TB1_LAST);
      tb1Cnt_nxt = tb1Tick_nxt ? '0 : tb1Cnt_r + 3'h1;
      tb2Tick_nxt = (tb2Cnt_r == bsq_pkg::TB2_LAST);
      tb2Cnt_nxt = tb2Tick_nxt ? '0 : tb2Cnt_r + 3'h1;
      filtTick_nxt = (filtCnt_r == bsq_pkg::FILT_LAST);
      filtCnt_nxt = filtTick_nxt ? '0 : filtCnt_r + 6'h01;
    end
    appTick_nxt = (tickCnt_r >= tickDiv_r);
    tickCnt_nxt = appTick_nxt ? '0 : tickCnt_r + 16'h0001;
    piTick_nxt = (piCnt_r == 18'(PI_PERIOD - 1));
    piCnt_nxt = piTick_nxt ? '0 : piCnt_r + 18'h00001;
    pwmCnt_nxt = (pwmCnt_r == 13'(PWM_PERIOD - 1)) ? '0 : pwmCnt_r + 13'h0001;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tb1Cnt_r <= '0;
      tb2Cnt_r <= '0;
      filtCnt_r <= '0;
      tickCnt_r <= '0;
      piCnt_r <= '0;
      pwmCnt_r <= '0;
      tb1Tick_r <= 1'b0;
      tb2Tick_r <= 1'b0;
      filtTick_r <= 1'b0;
      appTick_r <= 1'b0;
      piTick_r <= 1'b0;
    end
    else
    begin
      tb1Cnt_r <= tb1Cnt_nxt;
      tb2Cnt_r <= tb2Cnt_nxt;
      filtCnt_r <= filtCnt_nxt;
      tickCnt_r <= tickCnt_nxt;
      piCnt_r <= piCnt_nxt;
      pwmCnt_r <= pwmCnt_nxt;
      tb1Tick_r <= tb1Tick_nxt;
      tb2Tick_r <= tb2Tick_nxt;
      filtTick_r <= filtTick_nxt;
      appTick_r <= appTick_nxt;
      piTick_r <= piTick_nxt;
    end
  end

  // ------------------------------------------------------------
  // application state machine
  // ------------------------------------------------------------
  assign excNow = pinS.exc;
  assign ocEvent = ocArm_r && pinS.oc && !ocPrev_r;
  assign excEvent = |(excNow & ~excPrev_r);

  always_comb
  begin
    state_nxt = state_r;
    pwmReq_nxt = pwmReq_r;
    ocArm_nxt = ocArm_r;
    faultLed_nxt = faultLed_r;
    faultCode_nxt = faultCode_r;
    tbRun_nxt = tbRun_r;
    alignReq_nxt = 1'b0;
    speedRamp_nxt = speedRamp_r;
    speedOut_nxt = speedOut_r;
    speedStrobe_nxt = 1'b0;
    if (state_r == bsq_pkg::ST_RUN && piTick_r)
    begin
      speedRamp_nxt = rampToward(speedRamp_r, speedSet_r);
      speedOut_nxt = speedRamp_r;
      speedStrobe_nxt = 1'b1;
    end
    if (excEvent)
    begin
      state_nxt = bsq_pkg::ST_GLOBAL_FAULT;
      speedRamp_nxt = '0;
      speedOut_nxt = '0;
      pwmReq_nxt = 1'b0;
      ocArm_nxt = 1'b0;
      if (excNow[2] && !excPrev_r[2])
        faultCode_nxt = bsq_pkg::fault_code_microcode_exc;
      else if (excNow[1] && !excPrev_r[1])
        faultCode_nxt = bsq_pkg::fault_code_bad_opcode;
      else
        faultCode_nxt = bsq_pkg::fault_code_misc;
    end
    else if (ocEvent)
    begin
      state_nxt = bsq_pkg::ST_MOTOR_FAULT;
      speedRamp_nxt = '0;
      speedOut_nxt = '0;
      pwmReq_nxt = 1'b0;
      ocArm_nxt = 1'b0;
      faultLed_nxt = 1'b1;
      faultCode_nxt = bsq_pkg::fault_code_overcurrent;
    end
    else if (appTick_r)
    begin
      unique case (state_r)
        bsq_pkg::ST_INIT:
        begin
          pwmReq_nxt = 1'b0;
          ocArm_nxt = 1'b0;
          tbRun_nxt = 1'b1;
          state_nxt = pinS.sw ? bsq_pkg::ST_MOTOR_FAULT : bsq_pkg::ST_STOP;
        end
        bsq_pkg::ST_STOP:
          if (pinS.sw)
          begin
            state_nxt = bsq_pkg::ST_ENABLE;
            speedRamp_nxt = '0;
            speedOut_nxt = '0;
            pwmReq_nxt = 1'b1;
            alignReq_nxt = 1'b1;
          end
        bsq_pkg::ST_ENABLE:
          if (pinS.onOk)
          begin
            ocArm_nxt = 1'b1;
            state_nxt = bsq_pkg::ST_RUN;
          end
        bsq_pkg::ST_RUN:
          if (!pinS.sw)
          begin
            state_nxt = bsq_pkg::ST_DISABLE;
            speedRamp_nxt = '0;
            speedOut_nxt = '0;
            pwmReq_nxt = 1'b0;
            ocArm_nxt = 1'b0;
          end
        bsq_pkg::ST_DISABLE:
          if (pinS.offOk)
            state_nxt = bsq_pkg::ST_STOP;
        bsq_pkg::ST_MOTOR_FAULT:
          if (!pinS.sw)
          begin
            faultCode_nxt = bsq_pkg::fault_code_none;
            faultLed_nxt = 1'b0;
            state_nxt = bsq_pkg::ST_STOP;
          end
        bsq_pkg::ST_GLOBAL_FAULT:
          if (!pinS.sw)
          begin
            faultCode_nxt = bsq_pkg::fault_code_none;
            tbRun_nxt = 1'b0;
            state_nxt = bsq_pkg::ST_INIT;
          end
        default:
          state_nxt = bsq_pkg::ST_INIT;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_r <= bsq_pkg::ST_INIT;
      pwmReq_r <= 1'b0;
      ocArm_r <= 1'b0;
      faultLed_r <= 1'b0;
      faultCode_r <= bsq_pkg::fault_code_none;
      tbRun_r <= 1'b0;
      alignReq_r <= 1'b0;
      speedRamp_r <= '0;
      speedOut_r <= '0;
      speedStrobe_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      pwmReq_r <= pwmReq_nxt;
      ocArm_r <= ocArm_nxt;
      faultLed_r <= faultLed_nxt;
      faultCode_r <= faultCode_nxt;
      tbRun_r <= tbRun_nxt;
      alignReq_r <= alignReq_nxt;
      speedRamp_r <= speedRamp_nxt;
      speedOut_r <= speedOut_nxt;
      speedStrobe_r <= speedStrobe_nxt;
    end
  end

  // ------------------------------------------------------------
  // commutated complementary pwm stage
  // ------------------------------------------------------------
  assign pwmOn = pwmReq_r && (state_r == bsq_pkg::ST_RUN || state_r == bsq_pkg::ST_ENABLE);

  always_comb
  begin
    logic hiOn;
    logic loOn;
    logic [1:0] hiPh;
    logic [1:0] loPh;
    hiOn = (pwmCnt_r >= 13'(bsq_pkg::DEAD_CYC)) && (pwmCnt_r < dutyIn);
    loOn = ({1'b0, pwmCnt_r} >= {1'b0, dutyIn} + 14'(bsq_pkg::DEAD_CYC));
    hiPh = (commSector >= 3'h4) ? 2'h2 : ((commSector >= 3'h2) ? 2'h1 : 2'h0);
    loPh = (hiPh == 2'h2) ? 2'h0 : hiPh + 2'h1;
    pwm_nxt = '0;
    if (pwmOn)
    begin
      pwm_nxt.high[hiPh] = hiOn;
      pwm_nxt.low[hiPh] = loOn;
      pwm_nxt.low[loPh] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      pwm_r <= '0;
    else
      pwm_r <= pwm_nxt;
  end

  // ------------------------------------------------------------
  // apb register slave
  // ------------------------------------------------------------
  always_comb
  begin
    speedSet_nxt = speedSet_r;
    tickDiv_nxt = tickDiv_r;
    pGain_nxt = pGain_r;
    iGain_nxt = iGain_r;
    prdata_nxt = prdata_r;
    if (psel && penable && pwrite)
      unique case (paddr)
        bsq_pkg::REG_SPEED: speedSet_nxt = pwdata[15:0];
        bsq_pkg::REG_TICK: tickDiv_nxt = pwdata[15:0];
        bsq_pkg::REG_PGAIN: pGain_nxt = pwdata[23:0];
        bsq_pkg::REG_IGAIN: iGain_nxt = pwdata[23:0];
        default: prdata_nxt = prdata_r;
      endcase
    if (psel && !penable)
      unique case (paddr)
        bsq_pkg::REG_STATUS: prdata_nxt = {22'h0, faultCode_r, faultLed_r, ocArm_r, pwmOn, tbRun_r, state_r};
        bsq_pkg::REG_SPEED: prdata_nxt = {16'h0, speedSet_r};
        bsq_pkg::REG_TICK: prdata_nxt = {16'h0, tickDiv_r};
        bsq_pkg::REG_PGAIN: prdata_nxt = {8'h0, pGain_r};
        bsq_pkg::REG_IGAIN: prdata_nxt = {8'h0, iGain_r};
        bsq_pkg::REG_RAMP: prdata_nxt = {16'h0, speedRamp_r};
        bsq_pkg::REG_ENC: prdata_nxt = 32'(bsq_pkg::ENC_INC_PER_REV);
        bsq_pkg::REG_RANGE: prdata_nxt = {8'(bsq_pkg::POLE_PAIRS), 8'(bsq_pkg::SPEED_MIN_RPM),
                                          16'(bsq_pkg::SPEED_RANGE_RPM)};
        bsq_pkg::REG_PWMCFG: prdata_nxt = {16'(bsq_pkg::DEAD_TIME_NS), 16'(bsq_pkg::PWM_FREQ_HZ)};
        bsq_pkg::REG_CHMAP: prdata_nxt = {2'h0, bsq_pkg::CH_PWM_C[4:0], bsq_pkg::CH_PWM_B[4:0],
                                          bsq_pkg::CH_PWM_A[4:0], bsq_pkg::CH_DEC_IDX[4:0],
                                          bsq_pkg::CH_DEC_B[4:0], bsq_pkg::CH_DEC_A[4:0]};
        bsq_pkg::REG_TBCFG: prdata_nxt = {8'(bsq_pkg::FILT_SAMPLES), 8'(bsq_pkg::FILT_DIV),
                                          8'(bsq_pkg::TB2_DIV), 8'(bsq_pkg::TB1_DIV)};
        default: prdata_nxt = '0;
      endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      speedSet_r <= '0;
      tickDiv_r <= bsq_pkg::TICK_DIV_RST;
      pGain_r <= bsq_pkg::P_GAIN_RST;
      iGain_r <= bsq_pkg::I_GAIN_RST;
      prdata_r <= '0;
    end
    else
    begin
      speedSet_r <= speedSet_nxt;
      tickDiv_r <= tickDiv_nxt;
      pGain_r <= pGain_nxt;
      iGain_r <= iGain_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !regMapped(paddr);
  assign prdata = prdata_r;
  assign pwmOut = pwm_r;
  assign alignReq = alignReq_r;
  assign speedReqOut = speedOut_r;
  assign speedStrobe = speedStrobe_r;
  assign pGainOut = pGain_r;
  assign iGainOut = iGain_r;
  assign faultLed = faultLed_r;
  assign faultCode = faultCode_r;
  assign ocArmed = ocArm_r;
  assign timebaseOneTick = tb1Tick_r;
  assign timebaseTwoTick = tb2Tick_r;
  assign appState = state_r;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  init_exit_path_a: assert property (state_r == bsq_pkg::ST_INIT |=> state_r inside {bsq_pkg::ST_INIT,
    bsq_pkg::ST_STOP, bsq_pkg::ST_MOTOR_FAULT, bsq_pkg::ST_GLOBAL_FAULT})
    else $error("init left to a wrong state");
  init_to_stop_a: assert property (state_r == bsq_pkg::ST_INIT && appTick_r && !excEvent && !pinS.sw
    |=> state_r == bsq_pkg::ST_STOP && tbRun_r)
    else $error("init with switch off did not reach stop");
  oc_fault_a: assert property (ocEvent && !excEvent |=> state_r == bsq_pkg::ST_MOTOR_FAULT && faultLed_r
    && !pwmReq_r && speedRamp_r == '0 && faultCode_r == bsq_pkg::fault_code_overcurrent)
    else $error("over-current did not force motor fault");
  mfault_clear_a: assert property (state_r == bsq_pkg::ST_MOTOR_FAULT && appTick_r && !pinS.sw
    && !excEvent |=> state_r == bsq_pkg::ST_STOP && faultCode_r == bsq_pkg::fault_code_none)
    else $error("motor fault not cleared to stop");
  exc_fault_a: assert property (excEvent |=> state_r == bsq_pkg::ST_GLOBAL_FAULT && !pwmReq_r)
    else $error("exception did not force global fault");
  stop_pwm_off_a: assert property (state_r == bsq_pkg::ST_STOP [*2] |-> pwmOut == '0)
    else $error("pwm active in stop");
  enable_zero_a: assert property (state_r == bsq_pkg::ST_ENABLE |-> speedRamp_r == '0)
    else $error("speed not zero in enable");
  run_armed_a: assert property (state_r == bsq_pkg::ST_ENABLE ##1 state_r == bsq_pkg::ST_RUN |-> ocArm_r)
    else $error("run entered without over-current armed");
  disable_hold_a: assert property (state_r == bsq_pkg::ST_DISABLE && !pinS.offOk
    |=> state_r != bsq_pkg::ST_STOP)
    else $error("disable left without success");
  tb1_rate_a: assert property (tb1Tick_r && tbRun_r |-> ##1 !tb1Tick_r ##1 (tb1Tick_r || !tbRun_r))
    else $error("timebase one rate wrong");

endmodule
`default_nettype wire

// >>> sim/bsq_stage_model.sv
// power stage and encoder stand-in for the sequencer bench
`timescale 1ns/10ps
`default_nettype none
module bsq_stage_model (
  input wire logic clk_sys,
  input wire logic failOn,
  input wire logic failOff,
  output logic pwmOnOkPin,
  output logic pwmOffOkPin,
  output logic [2:0] encPin
);
  logic [11:0] cnt_r = 12'h000;
  always @(posedge clk_sys)
  begin
    cnt_r <= cnt_r + 12'h001;
  end
  // enable and disable acknowledges, refused on command
  assign pwmOnOkPin = !failOn;
  assign pwmOffOkPin = !failOff;
  // slow two-channel pattern, channel 0 toggling every 1024 cycles and channel 1 every 2048, with index, levels outlast the filter window
  assign encPin = {cnt_r[11] & cnt_r[10], cnt_r[11] ^ cnt_r[10], cnt_r[10]};
endmodule
`default_nettype wire

// >>> sim/bldc_drive_state_sequencer_tb.sv
// self-checking bench for the drive state sequencer
`timescale 1ns/10ps
`default_nettype none
module bldc_drive_state_sequencer_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rdv;
  logic pready, pslverr, errv, pwmOnOk, pwmOffOk, alignReq, strobe, faultLed, ocArmed;
  logic swOn = 1'b1;
  logic oc = 1'b0;
  logic failOn = 1'b1;
  logic failOff = 1'b0;
  logic [2:0] enc, faultCode;
  logic [15:0] speed;
  bsq_pkg::bsq_exc_type exc = 3'h0;
  bsq_pkg::bsq_pwm_type pwm;
  bsq_pkg::bsq_state_type st;
  logic tb1Tick, tb2Tick;
  logic encSeen = 1'b0;
  logic [2:0] encF;
  logic [23:0] pGain, iGain;
  int nStrobe = 0;
  int nTb1 = 0;
  int nTb2 = 0;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end
  bsq_stage_model stage (.clk_sys(clk_sys), .failOn(failOn), .failOff(failOff),
    .pwmOnOkPin(pwmOnOk), .pwmOffOkPin(pwmOffOk), .encPin(enc));
  bsq_sequencer #(.PWM_PERIOD(50), .PI_PERIOD(100)) dut (.clk_sys(clk_sys), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .switchOnPin(swOn),
    .overCurrentPin(oc), .excPin(exc), .pwmOnOkPin(pwmOnOk), .pwmOffOkPin(pwmOffOk),
    .encPin(enc), .commSector(3'h0), .dutyIn(13'h0014), .pwmOut(pwm), .alignReq(alignReq),
    .speedReqOut(speed), .speedStrobe(strobe), .pGainOut(pGain), .iGainOut(iGain), .faultLed(faultLed),
    .faultCode(faultCode), .ocArmed(ocArmed), .timebaseOneTick(tb1Tick), .timebaseTwoTick(tb2Tick),
    .encFilt(encF), .appState(st));
  task automatic summarize();
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic waitSt(input bsq_pkg::bsq_state_type s);
    int n;
    n = 0;
    while (st !== s && n < 3000)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk({29'h0, st}, {29'h0, s});
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (encF !== 3'h0)
      encSeen <= 1'b1;
    if (cyc == 60000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk_sys);
    chk({29'h0, st}, 32'h0);
    rst <= 1'b0;
    waitSt(bsq_pkg::ST_MOTOR_FAULT);
    swOn <= 1'b0;
    waitSt(bsq_pkg::ST_STOP);
    apb(1'b1, bsq_pkg::REG_TICK, 32'h3);
    apb(1'b0, bsq_pkg::REG_ENC, 32'h0);
    chk(rdv, 32'h7D0);
    apb(1'b0, bsq_pkg::REG_PGAIN, 32'h0);
    chk(rdv, 32'h4000);
    chk({8'h0, pGain}, 32'h4000);
    chk({8'h0, iGain}, 32'h1000);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, errv}, 32'h1);
    chk(rdv, 32'h0);
    swOn <= 1'b1;
    waitSt(bsq_pkg::ST_ENABLE);
    chk({31'h0, alignReq}, 32'h1);
    repeat (40) @(posedge clk_sys);
    chk({29'h0, st}, {29'h0, bsq_pkg::ST_ENABLE});
    chk({31'h0, pwm.low[1]}, 32'h1);
    failOn <= 1'b0;
    waitSt(bsq_pkg::ST_RUN);
    chk({31'h0, ocArmed}, 32'h1);
    apb(1'b1, bsq_pkg::REG_SPEED, 32'h64);
    repeat (400)
    begin
      @(posedge clk_sys);
      if (strobe === 1'b1)
        nStrobe++;
      if (tb1Tick === 1'b1)
        nTb1++;
      if (tb2Tick === 1'b1)
        nTb2++;
    end
    chk({31'h0, speed !== 16'h0}, 32'h1);
    chk(nStrobe, 32'h4);
    chk(nTb1, 32'hC8);
    chk(nTb2, 32'h32);
    oc <= 1'b1;
    waitSt(bsq_pkg::ST_MOTOR_FAULT);
    chk({29'h0, faultCode}, 32'h1);
    chk({31'h0, faultLed}, 32'h1);
    chk({16'h0, speed}, 32'h0);
    oc <= 1'b0;
    swOn <= 1'b0;
    waitSt(bsq_pkg::ST_STOP);
    swOn <= 1'b1;
    waitSt(bsq_pkg::ST_RUN);
    failOff <= 1'b1;
    swOn <= 1'b0;
    waitSt(bsq_pkg::ST_DISABLE);
    repeat (40) @(posedge clk_sys);
    chk({29'h0, st}, {29'h0, bsq_pkg::ST_DISABLE});
    chk({16'h0, speed}, 32'h0);
    failOff <= 1'b0;
    waitSt(bsq_pkg::ST_STOP);
    chk({26'h0, pwm}, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      exc <= bsq_pkg::bsq_exc_type'(3'h4 >> i);
      waitSt(bsq_pkg::ST_GLOBAL_FAULT);
      chk({29'h0, faultCode}, 32'(2 + i));
      exc <= 3'h0;
      waitSt(bsq_pkg::ST_INIT);
      waitSt(bsq_pkg::ST_STOP);
    end
    chk({31'h0, encSeen}, 32'h1);
    summarize();
  end
endmodule
`default_nettype wire
